// ---- verilog/afrs_host.sv ----
// host controller that configures and sequences the fast-rate converter
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - one input at top rate: two hold channels both routed to that pin
// - multi-input high-rate work uses sequential sampling, simultaneous select cleared
// - trigger source 111 selects auto-convert; high rates need it (the host sets 000 instead, in any rate mode, when the ctrl manual bit is set)
// - two or more hold channels need conversions per interrupt of at least 0001
// - 1 Msps needs an 83.33 ns conversion clock
// - 750 ksps with one hold channel needs a 95.24 ns conversion clock
// - 600 ksps with two or more hold channels needs 138.89 ns
// - every sampled pin routed to at least two hold channels in two-channel modes
// - at least one conversion clock of sampling between conversions
// - externally triggered conversions spaced to meet the least sampling time
// - after a channel change a full sampling period precedes conversion
// - after switching on, wait for the circuitry to settle before sampling
// - auto sample time never below one conversion clock
module afrs_host #(
  parameter int TCY_PS = 33333,
  parameter int SETTLE_CYCLES = 4000,
  parameter int MAN_SAMPLE_TADS = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire afrs_pkg::afrs_wb_req_t wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output afrs_pkg::afrs_dev_cfg_t dev_o
);

  localparam int DIV_1M = afrs_pkg::div_for(afrs_pkg::TAD_1M_PS, TCY_PS);
  localparam int DIV_750K = afrs_pkg::div_for(afrs_pkg::TAD_750K_PS, TCY_PS);
  localparam int DIV_600K = afrs_pkg::div_for(afrs_pkg::TAD_600K_PS, TCY_PS);

  if (DIV_600K > afrs_pkg::DIV_MAX || DIV_1M < 0 || SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535 ||
      MAN_SAMPLE_TADS < 1 || MAN_SAMPLE_TADS > 8) begin : g_bad_param
    $error("afrs_host: parameters outside what the sequencer can serve");
  end

  afrs_pkg::afrs_state_t state, next_state;
  afrs_pkg::afrs_dev_cfg_t cfg, next_cfg;
  logic [15:0] cnt, next_cnt;
  logic [7:0] tad_cyc, next_tad_cyc;
  logic [10:0] ctrl, next_ctrl;
  logic [15:0] pins, next_pins;
  logic go_pend, next_go_pend;
  logic conversions_per_irq_clamped, next_conversions_per_irq_clamped;
  logic [7:0] man_done, next_man_done;
  logic [31:0] dat_q, next_dat_q;
  logic ack_q, next_ack_q;

  logic bus_hit;
  logic wr_ctrl;
  logic [1:0] mode;
  logic [1:0] inputs;
  logic [3:0] conversions_per_irq_req;

  assign bus_hit = wb_req_i.cyc && wb_req_i.stb && !ack_q;
  assign wr_ctrl = bus_hit && wb_req_i.we && wb_req_i.adr == afrs_pkg::ADDR_CTRL;
  assign mode = ctrl[afrs_pkg::CTRL_MODE_LO +: 2];
  assign inputs = ctrl[afrs_pkg::CTRL_INPUTS_LO +: 2];
  assign conversions_per_irq_req = ctrl[afrs_pkg::CTRL_CONVERSIONS_PER_IRQ_LO +: 4];

  // wishbone slave: ack one cycle after the strobe, dropped the cycle after
  always_comb begin
    next_ack_q = bus_hit;
    next_dat_q = 32'h0000_0000;
    next_ctrl = ctrl;
    next_pins = pins;
    next_go_pend = go_pend;
    if (bus_hit && !wb_req_i.we) begin
      case (wb_req_i.adr)
        afrs_pkg::ADDR_CTRL: next_dat_q = {21'h000000, ctrl};
        afrs_pkg::ADDR_PINS: next_dat_q = {16'h0000, pins};
        afrs_pkg::ADDR_STATUS: next_dat_q = {16'h0000, man_done, conversions_per_irq_clamped, state, cfg.converter_on,
                                             state == afrs_pkg::ST_RUN};
        default: next_dat_q = 32'h0000_0000;
      endcase
    end
    if (wr_ctrl) begin
      if (wb_req_i.sel[0]) begin
        next_ctrl[7:0] = wb_req_i.dat[7:0];
      end
      if (wb_req_i.sel[1]) begin
        next_ctrl[9:8] = wb_req_i.dat[9:8];
        if (wb_req_i.dat[afrs_pkg::CTRL_GO]) begin
          next_go_pend = 1'b1;
        end
      end
    end
    if (bus_hit && wb_req_i.we && wb_req_i.adr == afrs_pkg::ADDR_PINS) begin
      if (wb_req_i.sel[0]) begin
        next_pins[7:0] = wb_req_i.dat[7:0];
      end
      if (wb_req_i.sel[1]) begin
        next_pins[15:8] = wb_req_i.dat[15:8];
      end
    end
    // a manual start is consumed only when taken by the sequencer
    if (state == afrs_pkg::ST_RUN && cfg.trigger_source_sel == afrs_pkg::TRIG_MANUAL && go_pend) begin
      next_go_pend = 1'b0;
    end
    next_ctrl[afrs_pkg::CTRL_GO] = 1'b0;
  end

  // sequencer
  always_comb begin
    next_state = state;
    next_cfg = cfg;
    next_cnt = cnt;
    next_tad_cyc = tad_cyc;
    next_conversions_per_irq_clamped = conversions_per_irq_clamped;
    next_man_done = man_done;
    if (cnt != 16'h0000) begin
      next_cnt = cnt - 16'h0001;
    end
    case (state)
      afrs_pkg::ST_OFF: begin
        // rate, routing and trigger fields are only reprogrammed while the converter is off
        next_cfg.converter_on = 1'b0;
        next_cfg.auto_sample_enable = 1'b0;
        next_cfg.sample_control = 1'b0;
        next_cfg.simultaneous_sample_sel = 1'b0;
        next_cfg.auto_sample_time = afrs_pkg::AUTO_SAMPLE_TADS;
        next_cfg.trigger_source_sel = ctrl[afrs_pkg::CTRL_MANUAL] ? afrs_pkg::TRIG_MANUAL
                                                                 : afrs_pkg::TRIG_AUTO;
        case (mode)
          afrs_pkg::MODE_1M: begin
            next_cfg.conv_clock_divider = 6'(DIV_1M);
            next_tad_cyc = 8'(afrs_pkg::TAD_1M_CYC);
          end
          afrs_pkg::MODE_750K: begin
            next_cfg.conv_clock_divider = 6'(DIV_750K);
            next_tad_cyc = 8'(afrs_pkg::TAD_750K_CYC);
          end
          default: begin
            next_cfg.conv_clock_divider = 6'(DIV_600K);
            next_tad_cyc = 8'(afrs_pkg::TAD_600K_CYC);
          end
        endcase
        if (mode == afrs_pkg::MODE_750K) begin
          next_cfg.hold_channel_count = afrs_pkg::HOLD_ONE;
          next_cfg.input_channel_select_reg = {4{pins[3:0]}};
          next_cfg.conversions_per_irq = conversions_per_irq_req;
          next_conversions_per_irq_clamped = 1'b0;
        end else begin
          if (inputs == afrs_pkg::INPUTS_ONE) begin
            next_cfg.hold_channel_count = afrs_pkg::HOLD_TWO;
            next_cfg.input_channel_select_reg = {4{pins[3:0]}};
          end else if (inputs == afrs_pkg::INPUTS_TWO) begin
            next_cfg.hold_channel_count = afrs_pkg::HOLD_FOUR;
            next_cfg.input_channel_select_reg = {{2{pins[7:4]}}, {2{pins[3:0]}}};
          end else begin
            next_cfg.hold_channel_count = afrs_pkg::HOLD_FOUR;
            next_cfg.input_channel_select_reg = pins;
          end
          // two or more hold channels need a conversions per interrupt value of at least 0001
          next_cfg.conversions_per_irq = (conversions_per_irq_req < afrs_pkg::CONVERSIONS_PER_IRQ_MIN_MULTI) ? afrs_pkg::CONVERSIONS_PER_IRQ_MIN_MULTI
                                                                               : conversions_per_irq_req;
          next_conversions_per_irq_clamped = conversions_per_irq_req < afrs_pkg::CONVERSIONS_PER_IRQ_MIN_MULTI;
        end
        // cnt still counts the post-abort gap; no restart before it ends
        if (ctrl[afrs_pkg::CTRL_EN] && cnt == 16'h0000) begin
          next_state = afrs_pkg::ST_WARM;
          next_cfg.converter_on = 1'b1;
          next_cnt = 16'(SETTLE_CYCLES);
        end
      end
      afrs_pkg::ST_WARM: begin
        // sampling only starts once the analog front end has settled
        if (cnt == 16'h0000) begin
          next_state = afrs_pkg::ST_RUN;
          // follow the trigger latched while off; a live ctrl edit must not mix the two modes
          next_cfg.auto_sample_enable = cfg.trigger_source_sel == afrs_pkg::TRIG_AUTO;
        end
      end
      afrs_pkg::ST_RUN: begin
        if (cfg.trigger_source_sel == afrs_pkg::TRIG_MANUAL && go_pend) begin
          next_state = afrs_pkg::ST_MSAMP;
          next_cfg.sample_control = 1'b1;
          // full sampling period even right after a channel change
          next_cnt = 16'(MAN_SAMPLE_TADS) * {8'h00, tad_cyc};
        end
      end
      afrs_pkg::ST_MSAMP: begin
        if (cnt == 16'h0000) begin
          next_state = afrs_pkg::ST_MCONV;
          next_cfg.sample_control = 1'b0;
          next_cnt = 16'(afrs_pkg::CONV_TADS) * {8'h00, tad_cyc};
        end
      end
      afrs_pkg::ST_MCONV: begin
        if (cnt == 16'h0000) begin
          next_state = afrs_pkg::ST_RUN;
          next_man_done = man_done + 8'h01;
        end
      end
      default: begin
        next_state = afrs_pkg::ST_OFF;
      end
    endcase
    // switching off aborts any sequence; hold off the gap before a restart
    if (!ctrl[afrs_pkg::CTRL_EN] && state != afrs_pkg::ST_OFF) begin
      next_state = afrs_pkg::ST_OFF;
      next_cfg.converter_on = 1'b0;
      next_cfg.auto_sample_enable = 1'b0;
      next_cfg.sample_control = 1'b0;
      next_cnt = 16'(afrs_pkg::ABORT_WAIT_TADS) * {8'h00, tad_cyc};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= afrs_pkg::ST_OFF;
      cfg <= '0;
      cnt <= 16'h0000;
      tad_cyc <= 8'h00;
      ctrl <= 11'h000;
      pins <= 16'h0000;
      go_pend <= 1'b0;
      conversions_per_irq_clamped <= 1'b0;
      man_done <= 8'h00;
      dat_q <= 32'h0000_0000;
      ack_q <= 1'b0;
    end else begin
      state <= next_state;
      cfg <= next_cfg;
      cnt <= next_cnt;
      tad_cyc <= next_tad_cyc;
      ctrl <= next_ctrl;
      pins <= next_pins;
      go_pend <= next_go_pend;
      conversions_per_irq_clamped <= next_conversions_per_irq_clamped;
      man_done <= next_man_done;
      dat_q <= next_dat_q;
      ack_q <= next_ack_q;
    end
  end

  assign wb_dat_o = dat_q;
  assign wb_ack_o = ack_q;
  assign dev_o = cfg;

endmodule : afrs_host
`default_nettype wire

// ---- inc/afrs_pkg.sv ----
// shared constants and types of the fast-rate converter sequencer host
package afrs_pkg;

  localparam int CLK_PS = 5000;

  // wishbone register byte offsets
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_PINS = 4'h8;

  // ctrl register fields
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_MANUAL = 3;
  localparam int CTRL_INPUTS_LO = 4;
  localparam int CTRL_CONVERSIONS_PER_IRQ_LO = 6;
  localparam int CTRL_GO = 10;

  // rate modes
  localparam logic [1:0] MODE_1M = 2'h0;
  localparam logic [1:0] MODE_750K = 2'h1;
  localparam logic [1:0] MODE_600K = 2'h2;

  // input count codes
  localparam logic [1:0] INPUTS_ONE = 2'h0;
  localparam logic [1:0] INPUTS_TWO = 2'h1;

  // device field encodings
  localparam logic [2:0] TRIG_MANUAL = 3'h0;
  localparam logic [2:0] TRIG_AUTO = 3'h7;
  localparam logic [1:0] HOLD_ONE = 2'h0;
  localparam logic [1:0] HOLD_TWO = 2'h1;
  localparam logic [1:0] HOLD_FOUR = 2'h2;
  localparam logic [4:0] AUTO_SAMPLE_TADS = 5'h02;
  localparam logic [3:0] CONVERSIONS_PER_IRQ_MIN_MULTI = 4'h1;
  localparam int CONV_TADS = 12;
  localparam int ABORT_WAIT_TADS = 2;
  localparam int DIV_MAX = 63;

  // conversion clock periods in ps
  localparam int TAD_1M_PS = 83330;
  localparam int TAD_750K_PS = 95240;
  localparam int TAD_600K_PS = 138890;

  localparam int TAD_1M_CYC = (TAD_1M_PS + CLK_PS - 1) / CLK_PS;
  localparam int TAD_750K_CYC = (TAD_750K_PS + CLK_PS - 1) / CLK_PS;
  localparam int TAD_600K_CYC = (TAD_600K_PS + CLK_PS - 1) / CLK_PS;

  // least divider value whose period is not below the target
  function automatic int div_for(input int tad_ps, input int tcy_ps);
    div_for = (2 * tad_ps + tcy_ps - 1) / tcy_ps - 1;
  endfunction : div_for

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_WARM = 5'h02,
    ST_RUN = 5'h04,
    ST_MSAMP = 5'h08,
    ST_MCONV = 5'h10
  } afrs_state_t;

  typedef struct packed {
    logic converter_on;
    logic [2:0] trigger_source_sel;
    logic auto_sample_enable;
    logic simultaneous_sample_sel;
    logic [1:0] hold_channel_count;
    logic [3:0] conversions_per_irq;
    logic [5:0] conv_clock_divider;
    logic [4:0] auto_sample_time;
    logic sample_control;
    logic [15:0] input_channel_select_reg;
  } afrs_dev_cfg_t;

  typedef struct packed {
    logic [3:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
    logic we;
    logic cyc;
    logic stb;
  } afrs_wb_req_t;

endpackage : afrs_pkg

// ---- test/afrs_checker.sv ----
// port checker for the converter sequencer host
`timescale 1ns/100ps
`default_nettype none
module afrs_checker #(
  parameter int TCY_PS = 33333
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire afrs_pkg::afrs_wb_req_t wb_req_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire afrs_pkg::afrs_dev_cfg_t dev_o
);
  localparam int D1 = (2 * afrs_pkg::TAD_1M_PS + TCY_PS - 1) / TCY_PS - 1;
  localparam int D2 = (2 * afrs_pkg::TAD_750K_PS + TCY_PS - 1) / TCY_PS - 1;
  localparam int D3 = (2 * afrs_pkg::TAD_600K_PS + TCY_PS - 1) / TCY_PS - 1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle after the request");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");
  a_auto_trigger: assert property (dev_o.auto_sample_enable
    |-> dev_o.trigger_source_sel == afrs_pkg::TRIG_AUTO)
    else $error("auto sampling without auto-convert trigger");
  a_seq_sampling: assert property (dev_o.converter_on |-> !dev_o.simultaneous_sample_sel)
    else $error("simultaneous sampling selected");
  a_conversions_per_irq_multi: assert property (dev_o.converter_on
    && dev_o.hold_channel_count != afrs_pkg::HOLD_ONE |-> dev_o.conversions_per_irq >= afrs_pkg::CONVERSIONS_PER_IRQ_MIN_MULTI)
    else $error("conversion count too low for several hold channels");
  a_sample_time: assert property (dev_o.auto_sample_enable
    |-> dev_o.auto_sample_time == afrs_pkg::AUTO_SAMPLE_TADS)
    else $error("auto sample time wrong");
  a_div_rate: assert property (dev_o.auto_sample_enable
    |-> dev_o.conv_clock_divider inside {D1, D2, D3})
    else $error("divider gives no supported rate");
  a_pin_pair: assert property (dev_o.converter_on
    && dev_o.hold_channel_count == afrs_pkg::HOLD_TWO
    |-> dev_o.input_channel_select_reg[3:0] == dev_o.input_channel_select_reg[7:4])
    else $error("paired hold channels on different pins");
  a_settle_wait: assert property ($rose(dev_o.converter_on) |-> !dev_o.auto_sample_enable [*4])
    else $error("sampling started before settling");
  a_off_quiet: assert property (!dev_o.converter_on
    |-> !dev_o.auto_sample_enable && !dev_o.sample_control)
    else $error("sampling while converter off");
  a_manual_only: assert property (dev_o.sample_control
    |-> dev_o.trigger_source_sel == afrs_pkg::TRIG_MANUAL)
    else $error("sample control raised outside manual trigger");
  a_sample_min: assert property ($rose(dev_o.sample_control) |-> dev_o.sample_control [*8])
    else $error("manual sampling period too short");
endmodule : afrs_checker
bind afrs_host afrs_checker #(.TCY_PS(TCY_PS)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dev_o(dev_o));
`default_nettype wire

// ---- test/afrs_dev_model.sv ----
// behavioural model of the converter driven by the host
`timescale 1ns/100ps
`default_nettype none
module afrs_dev_model #(
  parameter int TCY_PS = 33333
) (
  input wire logic clk_i,
  input wire afrs_pkg::afrs_dev_cfg_t dev_i,
  output logic [15:0] n_conv_o,
  output logic [1:0] chan_o
);
  int conv_clock_period;
  int cnt = 0;
  logic sample_control_q = 1'b0;
  initial n_conv_o = 16'h0;
  initial chan_o = 2'h0;
  // rounded up to whole cycles so the model is never faster than the part
  always_comb conv_clock_period = ((int'(dev_i.conv_clock_divider) + 1) * TCY_PS / 2 + 4999) / 5000;
  always @(posedge clk_i) begin
    sample_control_q <= dev_i.sample_control;
    cnt <= cnt + 1;
    if (!dev_i.converter_on) begin
      cnt <= 0;
      chan_o <= 2'h0;
    end else if (dev_i.auto_sample_enable &&
      cnt >= (dev_i.auto_sample_time + afrs_pkg::CONV_TADS) * conv_clock_period - 1) begin
      cnt <= 0;
      n_conv_o <= n_conv_o + 16'h1;
      chan_o <= dev_i.hold_channel_count == afrs_pkg::HOLD_ONE ? 2'h0 :
        dev_i.hold_channel_count == afrs_pkg::HOLD_TWO ? {1'b0, ~chan_o[0]} : chan_o + 2'h1;
    end else if (sample_control_q && !dev_i.sample_control) begin
      n_conv_o <= n_conv_o + 16'h1;
    end
  end
endmodule : afrs_dev_model
`default_nettype wire

// ---- test/test_afrs_host.sv ----
// self-checking bench for the converter sequencer host
`timescale 1ns/100ps
`default_nettype none
module test_afrs_host;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  afrs_pkg::afrs_wb_req_t req = '0;
  logic [31:0] rdat, q;
  logic ack;
  afrs_pkg::afrs_dev_cfg_t dev;
  logic [15:0] n_conv, c0;
  logic [1:0] chan;
  int n, n_mismatch = 0, n_tests = 0;
  logic [10:0] t_ctrl [3] = '{11'h000, 11'h0c2, 11'h154};
  logic [27:0] t_exp [3] = '{{2'h1, 4'h1, 6'h04, 16'h1111}, {2'h0, 4'h3, 6'h05, 16'h1111},
    {2'h2, 4'h5, 6'h08, 16'h2211}};
  afrs_host #(.SETTLE_CYCLES(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_dat_o(rdat),
    .wb_ack_o(ack), .dev_o(dev));
  afrs_dev_model dev_m (.clk_i(clk_i), .dev_i(dev), .n_conv_o(n_conv), .chan_o(chan));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    req <= '{adr: a, dat: d, sel: 4'hf, we: we, cyc: 1'b1, stb: 1'b1};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    req <= '0;
    chk("bus ack", 64'h1, {63'h0, ack});
  endtask : wb
  task automatic wait_run;
    int k;
    k = 0;
    do begin
      wb(1'b0, afrs_pkg::ADDR_STATUS, 32'h0);
      k++;
    end while (q[0] !== 1'b1 && k < 40);
  endtask : wait_run
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("dev after reset", 64'h0, dev);
    wb(1'b0, afrs_pkg::ADDR_STATUS, 32'h0);
    // idle ctrl asks one input at top rate with no conversion count, so the clamp flag shows
    chk("status after reset", 64'h84, q);
    wb(1'b1, 4'hc, 32'hffff);
    wb(1'b0, 4'hc, 32'h0);
    chk("unmapped read", 64'h0, q);
    wb(1'b0, afrs_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl untouched", 64'h0, q);
    $display("bus test done");
    wb(1'b1, afrs_pkg::ADDR_PINS, 32'h21);
    wb(1'b0, afrs_pkg::ADDR_PINS, 32'h0);
    chk("pins readback", 64'h21, q);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, afrs_pkg::ADDR_CTRL, {21'h0, t_ctrl[i]});
      wb(1'b1, afrs_pkg::ADDR_CTRL, {21'h0, t_ctrl[i] | 11'h1});
      wait_run;
      // only the first setting asks too few conversions for its two hold channels
      chk("status running", {i == 0, 7'h13}, q[7:0]);
      chk("fixed fields", {1'b1, afrs_pkg::TRIG_AUTO, 2'b10, afrs_pkg::AUTO_SAMPLE_TADS, 1'b0}, {dev.converter_on,
        dev.trigger_source_sel, dev.auto_sample_enable, dev.simultaneous_sample_sel, dev.auto_sample_time,
        dev.sample_control});
      chk("rate fields", t_exp[i], {dev.hold_channel_count, dev.conversions_per_irq, dev.conv_clock_divider,
        dev.input_channel_select_reg});
      c0 = n_conv;
      repeat (1000) @(posedge clk_i);
      chk("conversions run", 64'h1, {63'h0, n_conv > c0});
      // one hold channel stays put, two alternate, four walk in order
      chk("hold channel", (i == 1) ? 64'h0 : 64'((n_conv - c0) % ((i == 0) ? 16'h2 : 16'h4)), {62'h0, chan});
      wb(1'b1, afrs_pkg::ADDR_CTRL, {21'h0, t_ctrl[i]});
      repeat (2) @(posedge clk_i);
      chk("off fields", 64'h0, {dev.converter_on, dev.auto_sample_enable, dev.sample_control});
      // restart stays blocked for two conversion clocks after switching off
      repeat (100) @(posedge clk_i);
      $display("rate test %0d done", i);
    end
    wb(1'b1, afrs_pkg::ADDR_CTRL, 32'h00a);
    wb(1'b1, afrs_pkg::ADDR_CTRL, 32'h40b);
    c0 = n_conv;
    for (n = 0; n < 200 && dev.sample_control !== 1'b1; n++) @(posedge clk_i);
    chk("manual fields", {1'b1, afrs_pkg::TRIG_MANUAL, 1'b0}, {dev.sample_control, dev.trigger_source_sel,
      dev.auto_sample_enable});
    for (n = 0; n < 2000 && dev.sample_control !== 1'b0; n++) @(posedge clk_i);
    chk("sample span", 2 * afrs_pkg::TAD_750K_CYC + 1, n);
    repeat (12 * afrs_pkg::TAD_750K_CYC + 4) @(posedge clk_i);
    wb(1'b0, afrs_pkg::ADDR_STATUS, 32'h0);
    chk("manual done", 64'h1, q[15:8]);
    chk("manual conversion", c0 + 16'h1, n_conv);
    $display("manual test done");
    // reset while the converter is on must drop everything back to off
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, afrs_pkg::ADDR_STATUS, 32'h0);
    chk("status after mid-run reset", 64'h84, q);
    $display("reset test done");
    report_and_stop;
  end
endmodule : test_afrs_host
`default_nettype wire
